// file: flash_host_ctrl.sv
// host sequencer driving program, erase and status polling on a flash
`timescale 1ns/10ps
`include "flash_host_map.svh"
module flash_host_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_req_valid,
  input wire flash_host_pkg::req_s i_req,
  output logic o_req_ready,
  output logic o_resp_valid,
  output logic [7:0] o_resp_data,
  output logic o_busy,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  output logic [19:0] o_addr,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n
);
  // ===========================================================
  // top sequencer
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_WRITE = 6'h02, ST_READ = 6'h04,
    ST_POLL = 6'h08, ST_CHECK = 6'h10, ST_DONE = 6'h20
  } st_e;
  st_e st_reg, st_next;
  flash_host_pkg::req_s req_reg, req_next;
  logic [2:0] step_reg, step_next;
  logic [1:0] npoll_reg, npoll_next;
  logic [7:0] last_reg, last_next;
  logic [1:0] agree_reg, agree_next;
  logic [7:0] resp_reg, resp_next;
  logic rv_reg, rv_next;
  logic cyc_start;
  flash_host_pkg::cyc_s cyc;
  logic cyc_done;
  logic [7:0] cyc_rdata;
  // unlock writes indexed by step, shared by program and erase
  function automatic flash_host_pkg::cyc_s seq_cyc(input flash_host_pkg::req_s r,
    input logic [2:0] s);
    flash_host_pkg::cyc_s c;
    c.rd = 1'b0;
    c.addr = `UNLOCK_A1;
    c.data = `UNLOCK_D1;
    case (s)
      3'h1, 3'h4:
      begin
        c.addr = `UNLOCK_A2;
        c.data = `UNLOCK_D2;
      end
      3'h2: c.data = (r.op == flash_host_pkg::OP_PROG) ? `CMD_SETUP_PROG :
        `CMD_SETUP_ERASE;
      3'h0, 3'h3: c.data = `UNLOCK_D1;
      default: c = '0;
    endcase
    return c;
  endfunction
  // final write of each operation
  function automatic flash_host_pkg::cyc_s last_cyc(input flash_host_pkg::req_s r);
    flash_host_pkg::cyc_s c;
    c.rd = 1'b0;
    c.addr = r.addr;
    case (r.op)
      flash_host_pkg::OP_PROG: c.data = r.data; // R8 R7
      flash_host_pkg::OP_SECTOR: c.data = `CMD_SECTOR; // R11
      flash_host_pkg::OP_BLOCK: c.data = `CMD_BLOCK; // R12
      flash_host_pkg::OP_CHIP:
      begin
        c.addr = `UNLOCK_A1; // R15
        c.data = `CMD_CHIP;
      end
      default: c.data = 8'h00;
    endcase
    return c;
  endfunction
  function automatic logic [2:0] nwrites(input flash_host_pkg::op_e op);
    return (op == flash_host_pkg::OP_PROG) ? 3'h3 : 3'h5; // R8 R11 R12 R15
  endfunction
  // a status pair is settled when toggle bit stops and poll bit shows true value
  function automatic logic settled(input logic [7:0] a, input logic [7:0] b,
    input flash_host_pkg::req_s r);
    logic want;
    want = (r.op == flash_host_pkg::OP_PROG) ? r.data[`POLL_BIT] : 1'b1;
    return (a[`TOGGLE_BIT] == b[`TOGGLE_BIT]) && (b[`POLL_BIT] == want); // R19 R20
  endfunction
  always_comb
  begin
    st_next = st_reg;
    req_next = req_reg;
    step_next = step_reg;
    npoll_next = npoll_reg;
    last_next = last_reg;
    agree_next = agree_reg;
    resp_next = resp_reg;
    rv_next = 1'b0;
    cyc_start = 1'b0;
    cyc = '0;
    case (st_reg)
      ST_IDLE:
      begin
        if (i_req_valid)
        begin
          req_next = i_req;
          step_next = 3'h0;
          st_next = (i_req.op == flash_host_pkg::OP_READ) ? ST_READ : ST_WRITE;
        end
      end
      ST_READ:
      begin
        cyc.rd = 1'b1;
        cyc.addr = req_reg.addr;
        cyc_start = (step_reg == 3'h0);
        step_next = 3'h1;
        if (cyc_done)
        begin
          resp_next = cyc_rdata;
          rv_next = 1'b1;
          st_next = ST_IDLE;
        end
      end
      ST_WRITE:
      begin
        // one start per step; the cycle module ignores starts while busy or done
        cyc = (step_reg == nwrites(req_reg.op)) ? last_cyc(req_reg) :
          seq_cyc(req_reg, step_reg);
        cyc_start = 1'b1;
        if (cyc_done)
        begin
          if (step_reg == nwrites(req_reg.op))
          begin
            st_next = ST_POLL; // R17
            npoll_next = 2'h0;
            agree_next = 2'h0;
          end
          else
            step_next = step_reg + 3'h1;
        end
      end
      ST_POLL:
      begin
        cyc.rd = 1'b1;
        cyc.addr = req_reg.addr;
        cyc_start = 1'b1;
        if (cyc_done)
          st_next = ST_CHECK;
      end
      ST_CHECK:
      begin
        // one settled pair is not trusted; a second settled pair, on the next read, confirms
        if (settled(last_reg, cyc_rdata, req_reg) && npoll_reg != 2'h0)
        begin
          agree_next = agree_reg + 2'h1; // R18
          if (agree_reg == 2'h1)
            st_next = ST_DONE;
          else
            st_next = ST_POLL;
        end
        else
        begin
          agree_next = 2'h0;
          st_next = ST_POLL;
        end
        npoll_next = 2'h1;
        // kept for the next pair, so the toggle bit is compared across two reads
        last_next = cyc_rdata; // R20
      end
      ST_DONE:
      begin
        resp_next = cyc_rdata;
        rv_next = 1'b1;
        st_next = ST_IDLE; // R22
      end
      default: st_next = ST_IDLE;
    endcase
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st_reg <= ST_IDLE;
      req_reg <= '0;
      step_reg <= 3'h0;
      npoll_reg <= 2'h0;
      last_reg <= 8'h00;
      agree_reg <= 2'h0;
      resp_reg <= 8'h00;
      rv_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      st_reg <= st_next;
      req_reg <= req_next;
      step_reg <= step_next;
      npoll_reg <= npoll_next;
      last_reg <= last_next;
      agree_reg <= agree_next;
      resp_reg <= resp_next;
      rv_reg <= rv_next;
    end
  end
  flash_bus_cycle u_cyc (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_start(cyc_start),
    .i_cyc(cyc),
    .i_dq(i_dq),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n),
    .o_addr(o_addr),
    .o_dq(o_dq),
    .o_dq_oe(o_dq_oe)
  );
  // new requests only in idle, so no command reaches a busy device
  assign o_req_ready = (st_reg == ST_IDLE); // R22
  assign o_busy = (st_reg != ST_IDLE);
  assign o_resp_valid = rv_reg;
  assign o_resp_data = resp_reg;
  no_cmd_busy_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R22
    (st_reg == ST_POLL || st_reg == ST_CHECK) |-> o_we_n)
    else $error("write during status poll");
  done_confirm_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R18
    (st_reg == ST_DONE) |-> $past(agree_reg) == 2'h1)
    else $error("completion without two agreeing reads");
endmodule

// file: flash_host_map.svh
// constants for the parallel flash host controller
// Operation
// R1: host writes a command by pulling write strobe low with chip select low.
// R2: device takes address on last falling edge, data on first rising edge.
// R3: device idles low-power after a read, wakes on next read transition.
// R4: after power-up with chip select low, no idle before first address change.
// R5: device drives data only while chip select and output gate are low.
// R6: chip select high deselects the device, other controls ignored.
// R7: host programs a byte only after its sector was erased.
// R8: program is three unlock writes then address and data write.
// R9: internal program completes within 20 microseconds.
// R10: during program only status reads, commands ignored.
// R11: sector erase is six writes ending with 30h at sector address.
// R12: block erase is six writes ending with 50h at block address.
// R13: erase address on sixth falling edge, command on its rising edge.
// R14: commands during sector or block erase are ignored.
// R15: chip erase is six writes ending with 10h at 5555h.
// R16: chip erase starts on sixth rising edge, only status reads until done.
// R17: poll and toggle bits report completion after the launching strobe.
// R18: on inconsistent status, host re-reads twice, done only if both valid.
// R19: poll bit reads complement during program, zero during erase.
// R20: toggle bit alternates on consecutive reads while busy.
// R21: a wrong unlock write aborts the sequence back to read mode.
// R22: host waits for completion before issuing a new command.
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH
`define ADDR_W 20
`define UNLOCK_A1 20'h05555
`define UNLOCK_D1 8'haa
`define UNLOCK_A2 20'h02aaa
`define UNLOCK_D2 8'h55
`define CMD_SETUP_PROG 8'ha0
`define CMD_SETUP_ERASE 8'h80
`define CMD_SECTOR 8'h30
`define CMD_BLOCK 8'h50
`define CMD_CHIP 8'h10
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define PHASE_CYC 4'h3
`define REC_NS 1000
`define CLK_NS 40
`define REC_CYC ((`REC_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// file: flash_host_pkg.sv
// types for the parallel flash host controller
package flash_host_pkg;
  typedef enum logic [2:0] {OP_READ = 3'h0, OP_PROG = 3'h1, OP_SECTOR = 3'h2,
    OP_BLOCK = 3'h3, OP_CHIP = 3'h4} op_e;
  typedef struct packed {
    op_e op;
    logic [19:0] addr;
    logic [7:0] data;
  } req_s;
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] data;
    logic rd;
  } cyc_s;
endpackage

// file: flash_bus_cycle.sv
// one asynchronous bus cycle on the flash pins
`timescale 1ns/10ps
`include "flash_host_map.svh"
module flash_bus_cycle (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire flash_host_pkg::cyc_s i_cyc,
  input wire logic [7:0] i_dq,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [19:0] o_addr,
  output logic [7:0] o_dq,
  output logic o_dq_oe
);
  // ===========================================================
  // setup, strobe, hold phases
  logic [1:0] ph_reg, ph_next;
  logic [3:0] cnt_reg, cnt_next;
  flash_host_pkg::cyc_s cyc_reg, cyc_next;
  logic [7:0] rd_reg, rd_next;
  logic [7:0] s1_reg, s2_reg, s3_reg;
  logic done_next, done_reg;
  // triple sampler, value taken at strobe end only if last two stages agree, else old value kept
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      s1_reg <= 8'h00;
      s2_reg <= 8'h00;
      s3_reg <= 8'h00;
    end
    else if (i_ce)
    begin
      s1_reg <= i_dq;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // phase sequencing; address set before strobe falls so it is latched stable
  always_comb
  begin
    ph_next = ph_reg;
    cnt_next = cnt_reg;
    cyc_next = cyc_reg;
    rd_next = rd_reg;
    done_next = 1'b0;
    case (ph_reg)
      2'h0:
      begin
        // a start seen in the done cycle still carries the old step, so it is dropped
        if (i_start && !done_reg)
        begin
          cyc_next = i_cyc;
          ph_next = 2'h1;
          cnt_next = `PHASE_CYC;
        end
      end
      2'h1:
      begin
        if (cnt_reg == 4'h0)
        begin
          ph_next = 2'h2;
          cnt_next = `PHASE_CYC + `PHASE_CYC;
        end
        else
          cnt_next = cnt_reg - 4'h1;
      end
      2'h2:
      begin
        // hold strobe long enough for three-stage sampler to settle
        if (cnt_reg == 4'h0)
        begin
          if (s2_reg == s3_reg)
            rd_next = s3_reg;
          ph_next = 2'h3;
          cnt_next = `PHASE_CYC;
        end
        else
          cnt_next = cnt_reg - 4'h1;
      end
      default:
      begin
        if (cnt_reg == 4'h0)
        begin
          ph_next = 2'h0;
          done_next = 1'b1;
        end
        else
          cnt_next = cnt_reg - 4'h1;
      end
    endcase
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ph_reg <= 2'h0;
      cnt_reg <= 4'h0;
      cyc_reg <= '0;
      rd_reg <= 8'h00;
      done_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
      cyc_reg <= cyc_next;
      rd_reg <= rd_next;
      done_reg <= done_next;
    end
  end
  // pin drive: chip select low across the whole cycle, strobe only mid-cycle
  assign o_ce_n = (ph_reg == 2'h0); // R6
  assign o_we_n = !((ph_reg == 2'h2) && !cyc_reg.rd); // R1 R2
  assign o_oe_n = !((ph_reg == 2'h2) && cyc_reg.rd); // R5
  assign o_addr = cyc_reg.addr;
  assign o_dq = cyc_reg.data;
  assign o_dq_oe = (ph_reg != 2'h0) && !cyc_reg.rd; // never fight device drive
  assign o_rdata = rd_reg;
  assign o_done = done_reg;
  strobe_pair_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
    !(!o_we_n && !o_oe_n)) else $error("write and read strobe both low");
  strobe_cs_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
    (!o_we_n || !o_oe_n) |-> !o_ce_n) else $error("strobe without select");
  addr_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
    !o_we_n |-> $stable({o_addr, o_dq})) else $error("address or data moved under strobe");
  read_nodrive_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
    !o_oe_n |-> !o_dq_oe) else $error("host drives data during read");
endmodule

// file: flash_dev_model.sv
// behavioural byte-wide flash device facing the host controller
`timescale 1ns/10ps
`include "flash_host_map.svh"
module flash_dev_model #(
  parameter int PROG_NS = 5000,
  parameter int ERASE_NS = 40000
) (
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [19:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_dq_oe,
  output logic [7:0] o_bus,
  output int o_writes,
  output int o_ignored
);
  // ==========
  // array and command state
  logic [7:0] mem [0:1048575];
  logic [19:0] lat_addr;
  logic [7:0] last_q = 8'h00;
  logic [7:0] tgt = 8'h00;
  logic [7:0] rd;
  logic busy = 1'b0;
  logic erasing = 1'b0;
  logic tog = 1'b0;
  int step = 0;
  // blank part reads all ones
  initial
  begin
    o_writes = 0;
    o_ignored = 0;
    for (int i = 0; i < 1048576; i++) mem[i] = 8'hff;
  end
  // ==========
  // internal operation, timed in simulated time only
  task automatic start_op(input logic [7:0] kind, input logic [19:0] a, input logic [7:0] d);
    busy = 1'b1;
    erasing = (kind != 8'h00);
    tgt = d;
    fork
    begin
      int base;
      int n;
      base = (kind == `CMD_SECTOR) ? {a[19:12], 12'h000} : (kind == `CMD_BLOCK) ? {a[19:16], 16'h0000} : 0;
      n = (kind == `CMD_SECTOR) ? 4096 : (kind == `CMD_BLOCK) ? 65536 : 1048576;
      #(erasing ? ERASE_NS : PROG_NS);
      if (!erasing) mem[a] = mem[a] & d; // cells only clear without an erase
      else for (int i = 0; i < n; i++) mem[base + i] = 8'hff;
      busy = 1'b0;
    end
    join_none
  endtask
  // unlock walk; a stray write drops back to plain reads
  task automatic on_write(input logic [7:0] d);
    o_writes++;
    if (busy) o_ignored++;
    else case (step)
      0, 3: step = (lat_addr == `UNLOCK_A1 && d == `UNLOCK_D1) ? step + 1 : 0;
      1, 4: step = (lat_addr == `UNLOCK_A2 && d == `UNLOCK_D2) ? step + 1 : 0;
      2: step = (lat_addr != `UNLOCK_A1) ? 0 : (d == `CMD_SETUP_PROG) ? 6 :
        (d == `CMD_SETUP_ERASE) ? 3 : 0;
      6:
      begin
        step = 0;
        start_op(8'h00, lat_addr, d);
      end
      default:
      begin
        step = 0;
        if (d == `CMD_SECTOR || d == `CMD_BLOCK || (d == `CMD_CHIP && lat_addr == `UNLOCK_A1))
          start_op(d, lat_addr, d);
      end
    endcase
  endtask
  // address on the later falling strobe
  always @(negedge i_we_n or negedge i_ce_n)
    if (!i_we_n && !i_ce_n) lat_addr = i_addr;
  // data on the earlier rising strobe, the other still low
  always @(posedge i_we_n or posedge i_ce_n)
    if (i_we_n != i_ce_n) on_write(i_dq);
  // each read while busy flips the toggle bit
  always @(negedge i_oe_n)
    if (!i_ce_n && busy) tog = ~tog;
  // released bus shows the inverse of the last value, never a stale match
  always @(posedge i_oe_n) last_q = ~rd;
  // status while busy, array otherwise, with no wake-up penalty after idle
  assign rd = busy ? {erasing ? 1'b0 : ~tgt[7], tog, ~tgt[5:0]} : mem[i_addr];
  assign o_bus = i_dq_oe ? i_dq : (!i_ce_n && !i_oe_n) ? rd : last_q;
endmodule

// file: test_parallel_flash_command_engine.sv
// self-checking bench for the parallel flash host controller
`timescale 1ns/10ps
module test_parallel_flash_command_engine;
  // ==========
  // stimulus and wiring
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req_valid = 1'b0;
  logic i_ce = 1'b1;
  flash_host_pkg::req_s i_req = '0;
  logic o_req_ready, o_resp_valid, o_busy, o_dq_oe, o_ce_n, o_oe_n, o_we_n;
  logic [7:0] o_resp_data, o_dq, bus;
  logic [19:0] o_addr;
  int writes, ignored;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  // free-running reference clock
  always #20 i_ref_clk = ~i_ref_clk;
  flash_host_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
    .o_resp_valid(o_resp_valid), .o_resp_data(o_resp_data), .o_busy(o_busy), .i_dq(bus),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_addr(o_addr), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
    .o_we_n(o_we_n));
  flash_dev_model i_dev (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_addr(o_addr),
    .i_dq(o_dq), .i_dq_oe(o_dq_oe), .o_bus(bus), .o_writes(writes), .o_ignored(ignored));
  // ==========
  // shared tasks
  task automatic give_verdict();
    if (fail_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_int(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      fail_count++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  // one request; the bound on the answer covers the longest erase
  task automatic do_req(input flash_host_pkg::op_e op, input logic [19:0] a,
    input logic [7:0] d, output logic [7:0] q);
    int n;
    int w0;
    n = 0;
    w0 = writes;
    i_req_valid <= 1'b1;
    i_req <= '{op: op, addr: a, data: d};
    do @(posedge i_ref_clk); while (o_req_ready !== 1'b1);
    i_req_valid <= 1'b0;
    @(posedge i_ref_clk);
    cmp8({6'h00, o_req_ready, o_busy}, 8'h01);
    while (o_resp_valid !== 1'b1 && n < 5000)
    begin
      @(posedge i_ref_clk);
      n++;
    end
    q = o_resp_data;
    cmp_int(n < 5000, 1);
    cmp_int(writes - w0, (op == flash_host_pkg::OP_READ) ? 0 :
      (op == flash_host_pkg::OP_PROG) ? 4 : 6);
    cmp_int(ignored, 0);
  endtask
  task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
    logic [7:0] q;
    do_req(flash_host_pkg::OP_READ, a, 8'h00, q);
    cmp8(q, exp);
  endtask
  task automatic op(input flash_host_pkg::op_e o, input logic [19:0] a, input logic [7:0] d);
    logic [7:0] q;
    do_req(o, a, d, q);
  endtask
  // ==========
  // scenarios
  // frozen clock enable: an offered request must not be taken, pins stay idle
  task automatic t_freeze();
    i_ce <= 1'b0;
    i_req_valid <= 1'b1;
    i_req <= '{op: flash_host_pkg::OP_READ, addr: 20'h00000, data: 8'h00};
    repeat (4) @(posedge i_ref_clk);
    cmp8({6'h00, o_busy, o_ce_n}, 8'h01);
    i_req_valid <= 1'b0;
    i_ce <= 1'b1;
    @(posedge i_ref_clk);
    cmp8({6'h00, o_busy, o_ce_n}, 8'h01);
  endtask
  task automatic t_program();
    rd_chk(20'h12345, 8'hff);
    op(flash_host_pkg::OP_PROG, 20'h12345, 8'h3c);
    rd_chk(20'h12345, 8'h3c);
    op(flash_host_pkg::OP_PROG, 20'h13345, 8'ha5);
    op(flash_host_pkg::OP_PROG, 20'h12fff, 8'h01);
  endtask
  // neighbour sector in the same block must survive
  task automatic t_sector();
    op(flash_host_pkg::OP_SECTOR, 20'h12abc, 8'h00);
    rd_chk(20'h12345, 8'hff);
    rd_chk(20'h12fff, 8'hff);
    rd_chk(20'h13345, 8'ha5);
  endtask
  // last byte of one block against the first byte of the next
  task automatic t_block();
    op(flash_host_pkg::OP_PROG, 20'h2ffff, 8'h11);
    op(flash_host_pkg::OP_PROG, 20'h30000, 8'h22);
    op(flash_host_pkg::OP_BLOCK, 20'h20000, 8'h00);
    rd_chk(20'h2ffff, 8'hff);
    rd_chk(20'h30000, 8'h22);
    rd_chk(20'h13345, 8'ha5);
  endtask
  task automatic t_chip();
    op(flash_host_pkg::OP_CHIP, 20'h00000, 8'h00);
    rd_chk(20'h30000, 8'hff);
    rd_chk(20'h13345, 8'hff);
  endtask
  // ==========
  // hang guard: the run needs well under this many cycles
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  // main sequence; pins are idle while reset is held
  initial
  begin
    repeat (6) @(posedge i_ref_clk);
    cmp8({4'h0, o_dq_oe, o_ce_n, o_oe_n, o_we_n}, 8'h07);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    t_freeze();
    t_program();
    t_sector();
    t_block();
    t_chip();
    give_verdict();
  end
endmodule
